// file: urdr_pkg.sv
// urdr_pkg: constants, field layouts and types for the receive data recovery block
// assumes a single pclk domain; apb slave with 32-bit data
package urdr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] URDR_CTRL_OFS   = 12'h000;
  localparam logic [11:0] URDR_BAUD_OFS   = 12'h004;
  localparam logic [11:0] URDR_STAT_OFS   = 12'h008;
  localparam logic [11:0] URDR_DATA_OFS   = 12'h00C;
  localparam logic [11:0] URDR_IRQST_OFS  = 12'h010;
  localparam logic [11:0] URDR_IRQEN_OFS  = 12'h014;
  localparam logic [11:0] URDR_IRQCLR_OFS = 12'h018;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          URDR_CTRL_EN_BIT   = 0;
  localparam int          URDR_CTRL_LEN9_BIT = 1;
  localparam logic [15:0] URDR_BAUD_RESET    = 16'h0001;
  localparam int          URDR_ST_FULL_BIT   = 0;
  localparam int          URDR_ST_FE_BIT     = 1;
  localparam int          URDR_ST_NF_BIT     = 2;
  localparam int          URDR_ST_BUSY_BIT   = 3;
  localparam int          URDR_DATA_NINTH    = 8;
  localparam int          URDR_IRQ_W         = 3;

  // ----------------------------------------------------------------
  // oversampling figures
  // ----------------------------------------------------------------
  localparam logic [3:0] URDR_TICKS_PER_BIT = 4'hF;  // last tick index, 16 ticks
  localparam logic [3:0] URDR_T_V1          = 4'h3;
  localparam logic [3:0] URDR_T_V2          = 4'h5;
  localparam logic [3:0] URDR_T_V3          = 4'h7;
  localparam logic [3:0] URDR_T_S8          = 4'h8;
  localparam logic [3:0] URDR_T_S9          = 4'h9;
  localparam logic [3:0] URDR_T_S10         = 4'hA;
  localparam logic [3:0] URDR_DATA_BITS8    = 4'h8;
  localparam logic [3:0] URDR_DATA_BITS9    = 4'h9;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    URDR_IDLE,
    URDR_START,
    URDR_DATA,
    URDR_STOP
  } urdr_state_t;

  typedef struct packed {
    logic [8:0] data;
    logic       framing_error;
    logic       noise;
  } urdr_char_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } urdr_apb_req_t;

endpackage

// file: urdr_rx.sv
// urdr_rx: receive data recovery with 16x oversampling, apb registers and interrupt
// assumes apb master on pclk; serial_in_pin is asynchronous to pclk
//
// Notes on behaviour
// - the line is sampled on every oversample tick, sixteen ticks per bit.
// - the tick counter restarts at each start edge and on a falling line edge after a decided 1 in the data bits.
// - a start bit is hunted as a low sample after three high samples, at any phase.
// - the falling edge of a candidate start begins a sixteen-tick bit period.
// - ticks 3, 5, 7 verify the start: at most one high accepts, exactly one high is noise.
// - two or more highs at ticks 3, 5, 7 abandon the start and resume hunting.
// - data bits take the majority of ticks 8, 9, 10 and disagreement flags noise.
// - highs at ticks 8, 9, 10 of a verified start flag noise yet reception goes on.
// - the stop bit majority low sets framing error, disagreement sets noise.
// - framing error is set whenever the stop slot is not high, breaks included.
// - framing error rises in the same cycle as the receive-full flag.
// - inside the data bits a falling edge after a decided 1, outside ticks 8 to 10, realigns the tick counter.
// - stop sampling ends at tick 154 for 8-bit and 170 for 9-bit characters.
// - a length select bit picks 8 or 9 data bits; the ninth goes to its own field.
// - a finished character moves to the receive data buffer and sets receive-full.
// - the noise flag covers start, data and stop bits of a character or break.
`timescale 1ns/1ps
module urdr_rx
  import urdr_pkg::*;
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // serial line and interrupt
  input  wire logic         serial_in_pin,
  output logic              irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // three samples that do not all agree
  function automatic logic disagree3(input logic [2:0] s);
    return (s != 3'b000) && (s != 3'b111);
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic sync1_reg;
  logic sync2_reg;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= serial_in_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic        enable_reg;
  logic        len9_reg;
  logic [15:0] baud_div_reg;
  logic [8:0]  receive_data_buffer_reg;
  logic        receive_full_flag_reg;
  logic        framing_error_flag_reg;
  logic        noise_flag_reg;
  logic [URDR_IRQ_W-1:0] irq_stat_reg;
  logic [URDR_IRQ_W-1:0] irq_en_reg;
  logic        busy_reg;

  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic mapped;
  assign apb_access = psel & penable;
  assign apb_wr     = apb_access & pwrite;
  assign apb_rd     = apb_access & ~pwrite;
  assign mapped     = (paddr == URDR_CTRL_OFS)  || (paddr == URDR_BAUD_OFS)  ||
                      (paddr == URDR_STAT_OFS)  || (paddr == URDR_DATA_OFS)  ||
                      (paddr == URDR_IRQST_OFS) || (paddr == URDR_IRQEN_OFS) ||
                      (paddr == URDR_IRQCLR_OFS);

  // ----------------------------------------------------------------
  // oversample tick divider
  // ----------------------------------------------------------------
  logic [15:0] div_reg;
  logic        oversample_tick;

  // one pclk pulse per tick; the divider value is 16x baud already
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg         <= 16'h0000;
      oversample_tick <= 1'b0;
    end else if (!enable_reg || div_reg >= baud_div_reg) begin
      div_reg         <= 16'h0000;
      oversample_tick <= enable_reg;
    end else begin
      div_reg         <= div_reg + 16'h0001;
      oversample_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // recovery state machine
  // ----------------------------------------------------------------
  urdr_state_t state_reg;
  logic [3:0]  tick_reg;
  logic [3:0]  bit_cnt_reg;
  logic [2:0]  hist_reg;
  logic [2:0]  samp_reg;
  logic [8:0]  shift_reg;
  logic        prev_bit_reg;
  logic        char_nf_reg;
  logic        done_reg;
  urdr_char_t  done_char_reg;

  logic [3:0] nbits;
  logic       bit_val;
  logic [2:0] samp_next;
  logic       line_fall;
  assign nbits     = len9_reg ? URDR_DATA_BITS9 : URDR_DATA_BITS8;
  assign samp_next = {samp_reg[1:0], sync2_reg};
  assign bit_val   = maj3(samp_next);
  assign line_fall = (hist_reg == 3'b111) && !sync2_reg;

  // one tick per step; samples taken at ticks 8..10 drive decisions at tick 10
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= URDR_IDLE;
      tick_reg      <= 4'h0;
      bit_cnt_reg   <= 4'h0;
      hist_reg      <= 3'b111;
      samp_reg      <= 3'b000;
      shift_reg     <= 9'h000;
      prev_bit_reg  <= 1'b0;
      char_nf_reg   <= 1'b0;
      done_reg      <= 1'b0;
      done_char_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (!enable_reg) begin
        state_reg <= URDR_IDLE;
        hist_reg  <= 3'b111;
      end else if (oversample_tick) begin
        hist_reg <= {hist_reg[1:0], sync2_reg};
        tick_reg <= tick_reg + 4'h1;
        case (state_reg)
          URDR_IDLE: begin
            // phase-free hunt for 1,1,1 then 0
            if (line_fall) begin
              state_reg   <= URDR_START;
              tick_reg    <= 4'h2;  // edge sample counts as tick 1
              char_nf_reg <= 1'b0;
              samp_reg    <= 3'b000;
            end
          end
          URDR_START: begin
            if (tick_reg == URDR_T_V1 || tick_reg == URDR_T_V2 || tick_reg == URDR_T_V3 ||
                tick_reg == URDR_T_S8 || tick_reg == URDR_T_S9 || tick_reg == URDR_T_S10) begin
              samp_reg <= samp_next;
            end
            if (tick_reg == URDR_T_V3) begin
              if (maj3(samp_next)) begin
                state_reg <= URDR_IDLE;
                tick_reg  <= 4'h0;
              end else if (samp_next != 3'b000) begin
                char_nf_reg <= 1'b1;
              end
            end
            if (tick_reg == URDR_T_S10 && samp_next != 3'b000) begin
              char_nf_reg <= 1'b1;  // still a start bit
            end
            if (tick_reg == URDR_TICKS_PER_BIT) begin
              state_reg    <= URDR_DATA;  // counter wraps to 0
              bit_cnt_reg  <= 4'h0;
              prev_bit_reg <= 1'b0;
            end
          end
          URDR_DATA: begin
            // realign on a decided 1 followed by a low line
            // a fast sender's edge lands after tick 10, a slow one's before tick 8
            if (prev_bit_reg && line_fall &&
                (tick_reg < URDR_T_S8 || tick_reg > URDR_T_S10)) begin
              tick_reg <= 4'h2;
              if (bit_cnt_reg == nbits) begin
                state_reg <= URDR_STOP;  // early edge of a low stop slot
              end
            end
            if (tick_reg == URDR_T_S8 || tick_reg == URDR_T_S9 || tick_reg == URDR_T_S10) begin
              samp_reg <= samp_next;
            end
            if (tick_reg == URDR_T_S10) begin
              // lsb first into the top, shifted down
              shift_reg    <= {bit_val, shift_reg[8:1]};
              prev_bit_reg <= bit_val;
              if (disagree3(samp_next)) begin
                char_nf_reg <= 1'b1;
              end
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (tick_reg == URDR_TICKS_PER_BIT && bit_cnt_reg == nbits) begin
              state_reg <= URDR_STOP;
            end
          end
          URDR_STOP: begin
            if (tick_reg == URDR_T_S8 || tick_reg == URDR_T_S9 || tick_reg == URDR_T_S10) begin
              samp_reg <= samp_next;
            end
            // tick 10 of the stop slot: 154 or 170 ticks after the edge
            if (tick_reg == URDR_T_S10) begin
              state_reg                   <= URDR_IDLE;
              done_reg                    <= 1'b1;
              done_char_reg.framing_error <= !bit_val;
              done_char_reg.noise         <= char_nf_reg | disagree3(samp_next);
              done_char_reg.data          <= len9_reg ? shift_reg : {1'b0, shift_reg[8:1]};
              hist_reg                    <= 3'b000;  // need three highs before a new start
            end
          end
          default: begin
            state_reg <= URDR_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // status and data buffer
  // ----------------------------------------------------------------
  logic rd_data;
  assign rd_data = apb_rd && pready && (paddr == URDR_DATA_OFS);

  // a new character wins over the read that clears the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_data_buffer_reg <= 9'h000;
      receive_full_flag_reg   <= 1'b0;
      framing_error_flag_reg  <= 1'b0;
      noise_flag_reg          <= 1'b0;
    end else if (done_reg) begin
      receive_data_buffer_reg <= done_char_reg.data;
      receive_full_flag_reg   <= 1'b1;
      framing_error_flag_reg  <= done_char_reg.framing_error;
      noise_flag_reg          <= done_char_reg.noise;
    end else if (rd_data) begin
      receive_full_flag_reg  <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      noise_flag_reg         <= 1'b0;
    end
  end

  // busy shown while a character is in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_reg != URDR_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic wr_ok;
  assign wr_ok = apb_wr && pready;

  // control and baud writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg   <= 1'b0;
      len9_reg     <= 1'b0;
      baud_div_reg <= URDR_BAUD_RESET;
      irq_en_reg   <= '0;
    end else if (wr_ok) begin
      if (paddr == URDR_CTRL_OFS) begin
        enable_reg <= pwdata[URDR_CTRL_EN_BIT];
        len9_reg   <= pwdata[URDR_CTRL_LEN9_BIT];
      end
      if (paddr == URDR_BAUD_OFS) begin
        baud_div_reg <= pwdata[15:0];
      end
      if (paddr == URDR_IRQEN_OFS) begin
        irq_en_reg <= pwdata[URDR_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt: sticky events, write-one-to-clear, set wins
  // ----------------------------------------------------------------
  logic [URDR_IRQ_W-1:0] irq_set;
  logic [URDR_IRQ_W-1:0] irq_clr;
  assign irq_set = {3{done_reg}} & {done_char_reg.noise, done_char_reg.framing_error, 1'b1};
  assign irq_clr = (wr_ok && paddr == URDR_IRQCLR_OFS) ? pwdata[URDR_IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      irq          <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end
  end

  // ----------------------------------------------------------------
  // apb answer: one wait state, data registered
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_access && !pready;
      pslverr <= apb_access && !pready && !mapped;
      prdata  <= 32'h0000_0000;
      if (apb_rd && !pready) begin
        case (paddr)
          URDR_CTRL_OFS:  prdata <= {30'h0, len9_reg, enable_reg};
          URDR_BAUD_OFS:  prdata <= {16'h0, baud_div_reg};
          URDR_STAT_OFS:  prdata <= {28'h0, busy_reg, noise_flag_reg,
                                     framing_error_flag_reg, receive_full_flag_reg};
          URDR_DATA_OFS:  prdata <= {23'h0, receive_data_buffer_reg};
          URDR_IRQST_OFS: prdata <= {29'h0, irq_stat_reg};
          URDR_IRQEN_OFS: prdata <= {29'h0, irq_en_reg};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// file: urdr_rx_sva.sv
// urdr_rx_sva: port checks of the receive recovery block
// assumes one pclk domain; bound onto every urdr_rx
`timescale 1ns/1ps
module urdr_rx_sva (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // line and interrupt
  input wire logic        serial_in_pin,
  input wire logic        irq
);
  logic [9:0] low_age;
  logic [2:0] wr_age;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // ages since a low line and a write; irq has no other cause
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_age <= 10'h3FF;
      wr_age  <= 3'h7;
    end else begin
      low_age <= !serial_in_pin ? 10'h000 : low_age + {9'h000, low_age != 10'h3FF};
      wr_age  <= (pready && pwrite) ? 3'h0 : wr_age + {2'h0, wr_age != 3'h7};
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  wait_state_a: assert property (psel && $rose(penable) |=> pready)
    else $error("pready missing one cycle after access");
  ready_cause_a: assert property (pready |-> psel && penable)
    else $error("pready without an access");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (psel && $rose(penable) && paddr > 12'h018
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && $rose(penable) && paddr <= 12'h018 && paddr[1:0] == 2'h0
    |=> !pslverr) else $error("mapped access refused");
  irq_mask_a: assert property (pready && pwrite && paddr == 12'h014 && pwdata[2:0] == 3'h0
    |=> ##1 !irq [*4]) else $error("irq high while all masked");
  irq_cause_a: assert property ($rose(irq) |-> low_age < 10'h190 || wr_age < 3'h5)
    else $error("irq rose with no character on the line");
endmodule
bind urdr_rx urdr_rx_sva i_urdr_rx_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin), .irq(irq));

// file: urdr_line_model.sv
// urdr_line_model: remote transmitter on the receive line
// assumes bench pclk; the model drives the line high when idle
`timescale 1ns/1ps
module urdr_line_model (
  // clock
  input wire logic pclk,
  // serial line
  output logic     line
);
  int bit_clks = 32;  // 16 ticks of 2 pclk at the reset divider
  initial line = 1'b1;
  // ----------------------------------------------------------------
  // frame: low start, data lsb first, stop, then idle high
  // ----------------------------------------------------------------
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int nbit);
    logic [11:0] f;
    f = (nb == 9) ? {1'b1, stop, d, 1'b0} : {2'h3, stop, d[7:0], 1'b0};
    for (int b = 0; b < nb + 2; b++) begin
      for (int c = 0; c < bit_clks; c++) begin
        // one-tick glitch near mid bit, only where asked
        line <= f[b] ^ (b == nbit && c >= 18 && c < 20);
        @(posedge pclk);
      end
    end
    line <= 1'b1;
    repeat (2 * bit_clks) @(posedge pclk);
  endtask
  // short low pulse that is no start bit
  task automatic pulse(input int clks);
    line <= 1'b0;
    repeat (clks) @(posedge pclk);
    line <= 1'b1;
    repeat (64) @(posedge pclk);
  endtask
endmodule

// file: urdr_rx_test.sv
// urdr_rx_test: self-checking bench of the receive recovery block
// assumes urdr_pkg, urdr_rx, the line model and the bound checker
`timescale 1ns/1ps
module urdr_rx_test;
  import urdr_pkg::*;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  urdr_apb_req_t req = '0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          irq;
  logic          line;
  logic [31:0]   rd;
  logic          err;
  logic [31:0]   seed = 32'h0000267A;
  int            exp_q[$];
  int            irq_on = 1;
  int            mismatches = 0;
  int            checked = 0;
  int            nz[3] = '{0, 5, 9};
  always #25 pclk = ~pclk;
  urdr_rx i_urdr_rx (.pclk(pclk), .presetn(presetn), .psel(req.psel), .penable(req.penable),
    .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(line), .irq(irq));
  urdr_line_model i_urdr_line_model (.pclk(pclk), .line(line));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; waits for pready, never a fixed count
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // send a character and compare every result with the bench model
  task automatic rx(input logic [8:0] d, input int nb, input logic stop, input int nbit,
                    input int ticks);
    int n;
    logic [31:0] ev;
    ev = {29'h0, nbit >= 0, !stop, 1'b1};
    exp_q.push_back(nb == 9 ? d : {1'b0, d[7:0]});
    n = 0;
    fork
      i_urdr_line_model.send(d, nb, stop, nbit);
      while (irq !== 1'b1 && n < 800) begin
        @(posedge pclk);
        n++;
      end
    join
    chk("irq", irq_on, {31'h0, irq});
    if (ticks > 0) chk("done time", 1, n >= 2 * ticks && n <= 2 * ticks + 12);
    apb(1'b0, URDR_STAT_OFS, 0);
    chk("status", ev, rd & 32'h7);
    apb(1'b0, URDR_IRQST_OFS, 0);
    chk("irq status", ev, rd);
    apb(1'b0, URDR_DATA_OFS, 0);
    chk("data", exp_q.pop_front(), rd);
    apb(1'b1, URDR_IRQCLR_OFS, 32'h7);
    apb(1'b0, URDR_STAT_OFS, 0);
    chk("cleared", 0, rd & 32'h7);
    chk("irq low", 0, {31'h0, irq});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    #2000000;
    mismatches++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, URDR_CTRL_OFS, 0);
    chk("ctrl reset", 0, rd);
    apb(1'b0, URDR_BAUD_OFS, 0);
    chk("baud reset", {16'h0, URDR_BAUD_RESET}, rd);
    apb(1'b1, URDR_STAT_OFS, 32'hF);
    apb(1'b0, URDR_STAT_OFS, 0);
    chk("status read only", 0, rd);
    apb(1'b0, 12'h01C, 0);
    chk("unmapped", 1, {rd[30:0], err});
    $display("register test done");
    apb(1'b1, URDR_CTRL_OFS, 1);
    apb(1'b1, URDR_IRQEN_OFS, 1);
    repeat (3) begin
      seed = xs(seed);
      rx(seed[8:0], 8, 1'b1, -1, 154);
    end
    foreach (nz[i]) rx(9'h000, 8, 1'b1, nz[i], 154);
    rx(9'h03C, 8, 1'b0, -1, 154);
    rx(9'h000, 8, 1'b0, -1, 154);
    $display("eight bit test done");
    i_urdr_line_model.pulse(6);
    apb(1'b0, URDR_STAT_OFS, 0);
    chk("false start", 0, rd & 32'h7);
    // a fast and then a slow sender; both drift out of a bit without realignment
    i_urdr_line_model.bit_clks = 30;
    rx(9'h055, 8, 1'b1, -1, 0);
    i_urdr_line_model.bit_clks = 34;
    rx(9'h055, 8, 1'b1, -1, 0);
    i_urdr_line_model.bit_clks = 32;
    $display("start and resync test done");
    apb(1'b1, URDR_CTRL_OFS, 3);
    seed = xs(seed);
    rx(seed[8:0], 9, 1'b1, -1, 170);
    apb(1'b1, URDR_IRQEN_OFS, 0);
    irq_on = 0;
    rx(9'h1C3, 9, 1'b1, -1, 0);
    $display("nine bit and mask test done");
    give_verdict;
  end
endmodule
